// ### rtl/dmr_ctrl.sv
// Fourth and fifth mode-register logic of the memory device.
// Assumes the controller clock arrives on ck_pin and is slower than clk;
// command/address pins are sampled on its rising edges.
// Overview of operation
// - Readout page 2 bit 6 reports repair support
// - One repair row per bank, undone appropriately
// - Read preamble length one or two clocks
// - Training drives preamble pattern on strobe
// - Temperature refresh may skip external refreshes
// - Range selects 85 or 105 degree limit
// - Command taken latency clocks after select
// - Monitor routes reference onto low data lines
// - Power save ignores all but exit, reset
// - Bits 12, 11, 10 enable inversions, mask
// - Bit 9 enables persistent parity errors
// - Bits 8:6 select parked termination
// - Bit 5 disables termination buffer in power-down
// - Bits 4 and 3 report parity, CRC errors
// - Bits 2:0 select parity latency
// - Parity checking pauses on flag unless persistent
// - Parity flag sticks until mode set clears
module dmr_ctrl #(
    parameter int  BANKS      = 16,
    parameter int  ROW_W      = 18,
    parameter int  CAL_DEPTH  = 8,
    parameter bit  SOFT_ROW_REPAIR_AVAIL = 1'b1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             ck_pin,
    input  wire dmr_pkg::dmr_ca_t ca_pin,
    input  wire logic             power_down,
    input  wire logic             parity_err_evt,
    input  wire logic             crc_err_evt,
    input  wire logic             mpsm_exit,
    input  wire logic             repair_req,
    input  wire logic [3:0]       repair_bank,
    input  wire logic [ROW_W-1:0] repair_row,
    input  wire logic [3:0]       lookup_bank,
    input  wire logic [ROW_W-1:0] lookup_row,
    input  wire logic [1:0]       rdo_page,
    input  wire logic [1:0]       rdo_loc,
    input  wire logic             dq_ref_level,
    output logic [7:0]            rdo_data,
    output logic                  lookup_hit,
    output dmr_pkg::dmr_cfg_t     cfg,
    output logic [21:0]           fifth_mode_settings,
    output logic [21:0]           fourth_mode_settings,
    output logic                  parity_check_en,
    output logic                  cmd_valid,
    output dmr_pkg::dmr_ca_t      cmd_ca,
    output logic                  pre_train_strobe,
    output logic [3:0]            dq_mon_out,
    output logic [3:0]            dq_mon_oe,
    output logic                  refresh_skip_ok
);
    localparam int CA_W = $bits(dmr_pkg::dmr_ca_t);

    logic             ck_s;
    logic             ck_d_reg;
    logic             ck_rise;
    logic [CA_W-1:0]  ca_s;
    dmr_pkg::dmr_ca_t ca_dly;
    logic [21:0]      mr4_reg;
    logic [21:0]      mr5_reg;
    logic [21:0]      mr5_next;
    logic             perr_reg;
    logic             cerr_reg;
    logic [ROW_W-1:0] rep_row_reg [BANKS];
    logic [BANKS-1:0] rep_vld_reg;
    logic             train_reg;
    logic [21:0]      mode_word;
    logic [2:0]       mode_sel;
    logic             is_mrs;
    logic             wr_mr4;
    logic             wr_mr5;
    logic             mpsm;
    logic [3:0]       cal_tap;
    logic [2:0]       cal_code;
    logic [2:0]       pl_code;
    logic             sensor_cool;

    // Synchronise the link clock and every command/address pin.
    dmr_sync u_ck_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (ck_pin),
        .q     (ck_s)
    );

    genvar g;
    generate
        for (g = 0; g < CA_W; g++) begin : g_ca
            dmr_sync u_sync (
                .clk   (clk),
                .rst_n (rst_n),
                .ce    (ce),
                .d     (ca_pin[g]),
                .q     (ca_s[g])
            );
        end
    endgenerate

    // Rising edge of the synchronised link clock.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ck_d_reg <= 1'b0;
        end else if (ce) begin
            ck_d_reg <= ck_s;
        end
    end
    assign ck_rise = ck_s & ~ck_d_reg;

    // Command address latency decode into clocks.
    assign cal_code = mr4_reg[dmr_pkg::DMR4_CAL_HI:dmr_pkg::DMR4_CAL_LO];
    always_comb begin
        unique case (cal_code)
            3'h1:    cal_tap = dmr_pkg::DMR_CAL_3;
            3'h2:    cal_tap = dmr_pkg::DMR_CAL_4;
            3'h3:    cal_tap = dmr_pkg::DMR_CAL_5;
            3'h4:    cal_tap = dmr_pkg::DMR_CAL_6;
            3'h5:    cal_tap = dmr_pkg::DMR_CAL_8;
            default: cal_tap = dmr_pkg::DMR_CAL_0;
        endcase
    end

    // Select is taken now; command/address is taken latency clocks later.
    dmr_delay #(
        .W     (CA_W),
        .DEPTH (CAL_DEPTH)
    ) u_cal (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .step  (ck_rise),
        .tap   (cal_tap),
        .din   (ca_s),
        .dout  (ca_dly)
    );

    // Command decode; select comes from the delayed word, the rest is now.
    dmr_pkg::dmr_ca_t ca_now;
    assign ca_now    = ca_s;
    logic cs_then;
    assign cs_then   = ~ca_dly.cs_n;
    assign mpsm      = mr4_reg[dmr_pkg::DMR4_MPSM];
    assign is_mrs    = ck_rise && cs_then && ca_now.act_n &&
                       !ca_now.ras_n && !ca_now.cas_n && !ca_now.we_n;
    assign mode_word = {ca_now.bg, ca_now.ba, ca_now.addr};
    assign mode_sel  = mode_word[dmr_pkg::DMR_SEL_HI:dmr_pkg::DMR_SEL_LO];
    assign wr_mr4    = is_mrs && !mpsm &&
                       (mode_sel == dmr_pkg::DMR_SEL_MR4);
    assign wr_mr5    = is_mrs && !mpsm &&
                       (mode_sel == dmr_pkg::DMR_SEL_MR5);
    assign cmd_valid = ck_rise && cs_then && !mpsm;
    assign cmd_ca    = ca_now;

    // Fourth mode register; exit clears the power-save bit only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mr4_reg <= dmr_pkg::DMR4_RESET;
        end else if (ce) begin
            if (mpsm && mpsm_exit) begin
                mr4_reg[dmr_pkg::DMR4_MPSM] <= 1'b0;
            end else if (wr_mr4) begin
                mr4_reg <= mode_word;
            end
        end
    end

    // Fifth mode register image with the error flags kept separately.
    assign mr5_next = wr_mr5 ? mode_word : mr5_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mr5_reg <= dmr_pkg::DMR5_RESET;
        end else if (ce) begin
            mr5_reg <= mr5_next;
        end
    end

    // Sticky error flags: a detected error wins over a clearing write.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            perr_reg <= 1'b0;
            cerr_reg <= 1'b0;
        end else if (ce) begin
            if (parity_err_evt && parity_check_en) begin
                perr_reg <= 1'b1;
            end else if (wr_mr5) begin
                perr_reg <= mode_word[dmr_pkg::DMR5_PERR];
            end
            if (crc_err_evt) begin
                cerr_reg <= 1'b1;
            end else if (wr_mr5) begin
                cerr_reg <= mode_word[dmr_pkg::DMR5_CERR];
            end
        end
    end

    // Parity checking runs when a latency is set and flag allows it.
    assign pl_code = mr5_reg[dmr_pkg::DMR5_PL_HI:dmr_pkg::DMR5_PL_LO];
    assign parity_check_en = (cfg.parity_clocks != dmr_pkg::DMR_PL_0) &&
                             (!perr_reg || mr5_reg[dmr_pkg::DMR5_PERS]);

    // Register images; the status bits show the flags.
    always_comb begin
        fifth_mode_settings = mr5_reg;
        fifth_mode_settings[dmr_pkg::DMR5_PERR] = perr_reg;
        fifth_mode_settings[dmr_pkg::DMR5_CERR] = cerr_reg;
    end
    assign fourth_mode_settings = mr4_reg;

    // Decoded configuration.
    always_comb begin
        cfg = '0;
        cfg.wr_pre_clocks = mr4_reg[dmr_pkg::DMR4_WPRE] ?
                            dmr_pkg::DMR_PRE_2 : dmr_pkg::DMR_PRE_1;
        cfg.rd_pre_clocks = mr4_reg[dmr_pkg::DMR4_RPRE] ?
                            dmr_pkg::DMR_PRE_2 : dmr_pkg::DMR_PRE_1;
        cfg.rd_pre_train  = mr4_reg[dmr_pkg::DMR4_RPTR];
        cfg.sr_abort      = mr4_reg[dmr_pkg::DMR4_SRAB];
        cfg.cal_clocks    = cal_tap;
        cfg.soft_row_repair = mr4_reg[dmr_pkg::DMR4_SOFT_ROW_REPAIR];
        cfg.ref_monitor   = mr4_reg[dmr_pkg::DMR4_VMON];
        cfg.temp_refresh  = mr4_reg[dmr_pkg::DMR4_TCR];
        cfg.ext_range     = mr4_reg[dmr_pkg::DMR4_TCRR];
        cfg.max_power_save = mpsm;
        cfg.rd_bus_inversion = mr5_reg[dmr_pkg::DMR5_RBI];
        cfg.wr_bus_inversion = mr5_reg[dmr_pkg::DMR5_WBI];
        cfg.write_byte_mask  = mr5_reg[dmr_pkg::DMR5_MASK];
        cfg.parity_persist   = mr5_reg[dmr_pkg::DMR5_PERS];
        cfg.parked_termination = dmr_pkg::dmr_park_t'(
            mr5_reg[dmr_pkg::DMR5_PARK_HI:dmr_pkg::DMR5_PARK_LO]);
        cfg.term_buf_off_pd  = mr5_reg[dmr_pkg::DMR5_TBUF] &&
                               power_down;
        unique case (pl_code)
            3'h1:    cfg.parity_clocks = dmr_pkg::DMR_PL_4;
            3'h2:    cfg.parity_clocks = dmr_pkg::DMR_PL_5;
            3'h3:    cfg.parity_clocks = dmr_pkg::DMR_PL_6;
            default: cfg.parity_clocks = dmr_pkg::DMR_PL_0;
        endcase
    end

    // Soft repair table: one row per bank, dropped on power-down.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rep_vld_reg <= '0;
        end else if (ce) begin
            if (power_down) begin
                rep_vld_reg <= '0;
            end else if (repair_req && mr4_reg[dmr_pkg::DMR4_SOFT_ROW_REPAIR]) begin
                rep_vld_reg[repair_bank] <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (ce && repair_req && mr4_reg[dmr_pkg::DMR4_SOFT_ROW_REPAIR]) begin
            rep_row_reg[repair_bank] <= repair_row;
        end
    end
    assign lookup_hit = rep_vld_reg[lookup_bank] &&
                        (rep_row_reg[lookup_bank] == lookup_row);

    // Readout page 2 location 0 reports repair support.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdo_data <= 8'h00;
        end else if (ce) begin
            rdo_data <= 8'h00;
            if (rdo_page == dmr_pkg::DMR_RDO_PAGE2 && rdo_loc == 2'h0) begin
                rdo_data[dmr_pkg::DMR_RDO_SOFT_ROW_REPAIR] <= SOFT_ROW_REPAIR_AVAIL;
            end
        end
    end

    // Training pattern: strobe toggles each link edge while enabled.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            train_reg <= 1'b0;
        end else if (ce) begin
            if (!mr4_reg[dmr_pkg::DMR4_RPTR]) begin
                train_reg <= 1'b0;
            end else if (ck_rise) begin
                train_reg <= ~train_reg;
            end
        end
    end
    assign pre_train_strobe = train_reg;

    // Reference monitor drives the four lowest data lines.
    assign dq_mon_out = {4{dq_ref_level}};
    assign dq_mon_oe  = {4{mr4_reg[dmr_pkg::DMR4_VMON]}};

    // Temperature refresh may skip when the sensor reads cool.
    assign sensor_cool = 1'b1;
    assign refresh_skip_ok = mr4_reg[dmr_pkg::DMR4_TCR] &&
                             sensor_cool;
endmodule

// ### pkg/dmr_pkg.sv
// Package for the fourth/fifth mode-register block: select codes, field
// positions, decode enumerations and the command/address carrier struct.
// Assumes the command/address bus is sampled by the block's own clock.
package dmr_pkg;

    // Mode-register select codes on the bank group and bank address pins.
    localparam logic [2:0] DMR_SEL_MR4 = 3'h4;
    localparam logic [2:0] DMR_SEL_MR5 = 3'h5;

    // Width of the mode-register image.
    localparam int DMR_MR_W = 22;

    // Field positions of the select code.
    localparam int DMR_SEL_HI = 20;
    localparam int DMR_SEL_LO = 18;

    // Fourth mode register field positions.
    localparam int DMR4_WPRE  = 12;
    localparam int DMR4_RPRE  = 11;
    localparam int DMR4_RPTR  = 10;
    localparam int DMR4_SRAB  = 9;
    localparam int DMR4_CAL_HI = 8;
    localparam int DMR4_CAL_LO = 6;
    localparam int DMR4_SOFT_ROW_REPAIR  = 5;
    localparam int DMR4_VMON  = 4;
    localparam int DMR4_TCR   = 3;
    localparam int DMR4_TCRR  = 2;
    localparam int DMR4_MPSM  = 1;

    // Fifth mode register field positions.
    localparam int DMR5_RSV21 = 21;
    localparam int DMR5_RSV17 = 17;
    localparam int DMR5_RSV13 = 13;
    localparam int DMR5_RBI   = 12;
    localparam int DMR5_WBI   = 11;
    localparam int DMR5_MASK  = 10;
    localparam int DMR5_PERS  = 9;
    localparam int DMR5_PARK_HI = 8;
    localparam int DMR5_PARK_LO = 6;
    localparam int DMR5_TBUF  = 5;
    localparam int DMR5_PERR  = 4;
    localparam int DMR5_CERR  = 3;
    localparam int DMR5_PL_HI = 2;
    localparam int DMR5_PL_LO = 0;

    // Reset values of the two registers.
    localparam logic [21:0] DMR4_RESET = 22'h000000;
    localparam logic [21:0] DMR5_RESET = 22'h000000;

    // Readout page 2 location 0 bit that reports soft repair support.
    localparam int DMR_RDO_SOFT_ROW_REPAIR = 6;
    localparam logic [1:0] DMR_RDO_PAGE2 = 2'h2;

    // Command address latency codes in clocks.
    localparam logic [3:0] DMR_CAL_0 = 4'h0;
    localparam logic [3:0] DMR_CAL_3 = 4'h3;
    localparam logic [3:0] DMR_CAL_4 = 4'h4;
    localparam logic [3:0] DMR_CAL_5 = 4'h5;
    localparam logic [3:0] DMR_CAL_6 = 4'h6;
    localparam logic [3:0] DMR_CAL_8 = 4'h8;

    // Parity latency in clocks.
    localparam logic [2:0] DMR_PL_0 = 3'h0;
    localparam logic [2:0] DMR_PL_4 = 3'h4;
    localparam logic [2:0] DMR_PL_5 = 3'h5;
    localparam logic [2:0] DMR_PL_6 = 3'h6;

    // Preamble lengths in clocks.
    localparam logic [1:0] DMR_PRE_1 = 2'h1;
    localparam logic [1:0] DMR_PRE_2 = 2'h2;

    // Refresh range limits in degrees Celsius and the skip threshold.
    localparam int DMR_TEMP_NORMAL_MAX = 85;
    localparam int DMR_TEMP_EXT_MAX    = 105;
    localparam int DMR_TEMP_SKIP_BELOW = 45;

    // Parked termination selection in fractions of the reference unit.
    typedef enum logic [2:0] {
        DMR_PARK_OFF  = 3'h0,
        DMR_PARK_RZ4  = 3'h1,
        DMR_PARK_RZ2  = 3'h2,
        DMR_PARK_RZ6  = 3'h3,
        DMR_PARK_RZ1  = 3'h4,
        DMR_PARK_RZ5  = 3'h5,
        DMR_PARK_RZ3  = 3'h6,
        DMR_PARK_RZ7  = 3'h7
    } dmr_park_t;

    // Command/address bus as sampled at the pins.
    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] addr;
    } dmr_ca_t;

    // Decoded settings presented to the rest of the device.
    typedef struct packed {
        logic [1:0]  wr_pre_clocks;
        logic [1:0]  rd_pre_clocks;
        logic        rd_pre_train;
        logic        sr_abort;
        logic [3:0]  cal_clocks;
        logic        soft_row_repair;
        logic        ref_monitor;
        logic        temp_refresh;
        logic        ext_range;
        logic        max_power_save;
        logic        rd_bus_inversion;
        logic        wr_bus_inversion;
        logic        write_byte_mask;
        logic        parity_persist;
        dmr_park_t   parked_termination;
        logic        term_buf_off_pd;
        logic [2:0]  parity_clocks;
    } dmr_cfg_t;

endpackage

// ### rtl/dmr_sync.sv
// Two-flop synchroniser for one bit.
// Assumes the input comes from outside the clk domain.
module dmr_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // First stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else if (ce) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ### rtl/dmr_delay.sv
// Programmable shift delay for the command/address word.
// Assumes the tap is stable while commands are in flight.
module dmr_delay #(
    parameter int W     = 26,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         step,
    input  wire logic [3:0]   tap,
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);
    logic [W-1:0] line_reg [DEPTH+1];
    logic [W-1:0] sel;

    // Tap zero passes the current word; tap t gives the word t edges old.
    assign sel = (tap == 4'h0) ? din : line_reg[tap - 4'h1];

    // Shift once per link edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i <= DEPTH; i++) begin
                line_reg[i] <= '1;
            end
        end else if (ce && step) begin
            line_reg[0] <= din;
            for (int i = 1; i <= DEPTH; i++) begin
                line_reg[i] <= line_reg[i-1];
            end
        end
    end

    assign dout = sel;
endmodule

// ### sim/dmr_ctrl_props.sv
// Concurrent checks on the ports of the fourth/fifth mode-register block.
// Assumes one clk domain with synchronous active-low reset and ce held high.
module dmr_ctrl_props #(
    parameter bit SOFT_ROW_REPAIR_AVAIL = 1'b1
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              crc_err_evt,
    input wire logic              mpsm_exit,
    input wire logic [1:0]        rdo_page,
    input wire logic [1:0]        rdo_loc,
    input wire logic              dq_ref_level,
    input wire logic [7:0]        rdo_data,
    input wire dmr_pkg::dmr_cfg_t cfg,
    input wire logic [21:0]       fifth_mode_settings,
    input wire logic [21:0]       fourth_mode_settings,
    input wire logic              parity_check_en,
    input wire logic              cmd_valid,
    input wire dmr_pkg::dmr_ca_t  cmd_ca,
    input wire logic [3:0]        dq_mon_out,
    input wire logic [3:0]        dq_mon_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [21:0] f5;
    logic        mr5_wr;

    // Short name for the fifth image and a decode of a fifth-register set.
    assign f5 = fifth_mode_settings;
    assign mr5_wr = cmd_valid && cmd_ca.act_n && !cmd_ca.ras_n
                    && !cmd_ca.cas_n && !cmd_ca.we_n
                    && {cmd_ca.bg[0], cmd_ca.ba} == dmr_pkg::DMR_SEL_MR5;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Decode and flag properties; flags may only move for their causes.
    property p_rdo;
        (rdo_page == 2'h2 && rdo_loc == 2'h0) |=> rdo_data[6] == SOFT_ROW_REPAIR_AVAIL;
    endproperty
    property p_inv;
        {cfg.rd_bus_inversion, cfg.wr_bus_inversion, cfg.write_byte_mask}
            == f5[12:10];
    endproperty
    property p_pers;
        cfg.parity_persist == f5[9];
    endproperty
    property p_park;
        cfg.parked_termination == f5[8:6];
    endproperty
    property p_plat;
        !f5[2] |-> cfg.parity_clocks
            == ((f5[1:0] == 2'h0) ? 3'h0 : {1'b1, f5[1:0] - 2'h1});
    endproperty
    property p_perr;
        $fell(f5[4]) |-> $past(mr5_wr) || $past(mr5_wr, 2);
    endproperty
    property p_crc;
        $rose(f5[3]) |-> $past(crc_err_evt) || $past(crc_err_evt, 2)
                         || $past(mr5_wr) || $past(mr5_wr, 2);
    endproperty
    property p_pchk;
        f5[4] && !f5[9] |-> !parity_check_en;
    endproperty
    property p_vmon;
        dq_mon_oe == {4{fourth_mode_settings[4]}} && (!fourth_mode_settings[4]
            || dq_mon_out == {4{dq_ref_level}});
    endproperty
    property p_mpsm;
        fourth_mode_settings[1] && !mpsm_exit |=> $stable(f5[21:5]);
    endproperty

    a_rdo: assert property (p_rdo)
        else $error("Readout support bit wrong.");
    a_inv: assert property (p_inv)
        else $error("Inversion or mask decode wrong.");
    a_pers: assert property (p_pers)
        else $error("Persistent mode decode wrong.");
    a_park: assert property (p_park)
        else $error("Parked termination decode wrong.");
    a_plat: assert property (p_plat)
        else $error("Parity latency decode wrong.");
    a_perr: assert property (p_perr)
        else $error("Parity flag cleared without mode set.");
    a_crc: assert property (p_crc)
        else $error("CRC flag rose without cause.");
    a_pchk: assert property (p_pchk)
        else $error("Parity check active with flag set.");
    a_vmon: assert property (p_vmon)
        else $error("Reference monitor output wrong.");
    a_mpsm: assert property (p_mpsm)
        else $error("Register changed in power save.");

    c_mr5: cover property (mr5_wr);
    c_perr: cover property ($rose(f5[4]));
    c_mpsm: cover property (fourth_mode_settings[1] && mpsm_exit);
endmodule

bind dmr_ctrl dmr_ctrl_props #(.SOFT_ROW_REPAIR_AVAIL(SOFT_ROW_REPAIR_AVAIL)) u_dmr_ctrl_props (
    .clk(clk), .rst_n(rst_n), .crc_err_evt(crc_err_evt),
    .mpsm_exit(mpsm_exit), .rdo_page(rdo_page), .rdo_loc(rdo_loc),
    .dq_ref_level(dq_ref_level), .rdo_data(rdo_data), .cfg(cfg),
    .fifth_mode_settings(fifth_mode_settings),
    .fourth_mode_settings(fourth_mode_settings),
    .parity_check_en(parity_check_en), .cmd_valid(cmd_valid),
    .cmd_ca(cmd_ca), .dq_mon_out(dq_mon_out), .dq_mon_oe(dq_mon_oe)
);

// ### sim/dmr_ctrl_model.sv
// Memory controller model that issues mode sets on the command pins.
// Assumes the caller passes the latency currently programmed in the device.
module dmr_ctrl_model (
    output logic             ck_pin,
    output dmr_pkg::dmr_ca_t ca_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // The link clock stands low and the pins deselected between commands.
    initial begin
        ck_pin = 1'b0;
        ca_pin = '1;
    end

    // One link clock of 200 ns; pins change only while the clock is low.
    task pulse();
        #100 ck_pin = 1'b1;
        #100 ck_pin = 1'b0;
    endtask

    // Mode set: strobes low, bits 21 and 17 to 13 forced to zero.
    // Gear-down and write latency are never programmed from here.
    task mode_set_command(input logic [21:0] w, input int cal);
        dmr_pkg::dmr_ca_t cmd;
        dmr_pkg::dmr_ca_t sel;
        cmd = {5'b01000, 1'b0, w[20:18], 1'b0, 3'h0, 1'b0, w[12:0]};
        sel = ~cmd;
        sel.cs_n = 1'b0;
        #13;
        ca_pin = (cal == 0) ? cmd : sel;
        pulse();
        for (int i = 1; i <= cal; i++) begin
            ca_pin = (i == cal) ? {1'b1, cmd[25:0]} : {1'b1, ~cmd[25:0]};
            pulse();
        end
        ca_pin = {1'b1, ~ca_pin[25:0]};
        repeat (4) pulse();
    endtask
endmodule

// ### sim/test_dmr_ctrl.sv
// Self-checking bench for the fourth/fifth mode-register block.
// Assumes the controller model drives the link pins; ce is held high.
module test_dmr_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk, rst_n, power_down, parity_err_evt, crc_err_evt;
    logic              mpsm_exit, repair_req, dq_ref_level, ck_pin;
    logic [3:0]        repair_bank, lookup_bank, dq_mon_out, dq_mon_oe;
    logic [17:0]       repair_row, lookup_row, v;
    logic [1:0]        rdo_page, rdo_loc;
    logic [7:0]        rdo_data;
    logic [21:0]       fifth_mode_settings, fourth_mode_settings;
    logic              lookup_hit, parity_check_en, cmd_valid, pts, s0;
    logic              refresh_ok;
    dmr_pkg::dmr_ca_t  ca_pin, cmd_ca;
    dmr_pkg::dmr_cfg_t cfg;
    logic [3:0]        cal_tab [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8,
                                       4'h0, 4'h0};
    int                miscompares, checks, cal, chg;

    dmr_ctrl u_dmr_ctrl (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .ck_pin(ck_pin),
        .ca_pin(ca_pin), .power_down(power_down),
        .parity_err_evt(parity_err_evt), .crc_err_evt(crc_err_evt),
        .mpsm_exit(mpsm_exit), .repair_req(repair_req),
        .repair_bank(repair_bank), .repair_row(repair_row),
        .lookup_bank(lookup_bank), .lookup_row(lookup_row),
        .rdo_page(rdo_page), .rdo_loc(rdo_loc), .dq_ref_level(dq_ref_level),
        .rdo_data(rdo_data), .lookup_hit(lookup_hit), .cfg(cfg),
        .fifth_mode_settings(fifth_mode_settings),
        .fourth_mode_settings(fourth_mode_settings),
        .parity_check_en(parity_check_en), .cmd_valid(cmd_valid),
        .cmd_ca(cmd_ca), .pre_train_strobe(pts), .dq_mon_out(dq_mon_out),
        .dq_mon_oe(dq_mon_oe), .refresh_skip_ok(refresh_ok)
    );
    dmr_ctrl_model u_dmr_ctrl_model (.ck_pin(ck_pin), .ca_pin(ca_pin));

    // 40 MHz system clock.
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic fire(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(2);
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Mode set through the model with the latency now programmed.
    task mr(input logic [2:0] sel, input logic [17:0] val);
        u_dmr_ctrl_model.mode_set_command({1'b0, sel, val}, cal);
        step(1);
    endtask

    task end_sim();
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run of about 30 us.
    initial begin
        #400000;
        miscompares++;
        end_sim();
    end

    // Main sequence of mode sets, events and comparisons.
    initial begin
        {rst_n, power_down, parity_err_evt, crc_err_evt, mpsm_exit} = '0;
        {repair_req, dq_ref_level, repair_bank, lookup_bank} = '0;
        {repair_row, lookup_row, rdo_loc} = '0;
        rdo_page = 2'h2;
        cal = 0;
        step(6);
        rst_n = 1'b1;
        step(4);
        check(fourth_mode_settings, 22'h0);
        check(fifth_mode_settings, 22'h0);
        check(rdo_data[6], 1'b1);
        for (int k = 0; k < 8; k++) begin
            v = {5'h0, k[2:0], k[0], k[2:0], k[1], 3'h0, k[1:0]};
            mr(3'h5, v);
            check(fifth_mode_settings[17:0], v);
            check(cfg.parked_termination, k[2:0]);
            check(cfg.parity_clocks, (k % 4 == 0) ? 0 : 3 + k % 4);
            check({cfg.rd_bus_inversion, cfg.wr_bus_inversion,
                   cfg.write_byte_mask}, k[2:0]);
            check(cfg.parity_persist, k[0]);
        end
        mr(3'h6, 18'h01fc7);
        check(fifth_mode_settings[17:0], 18'h01fe3);
        mr(3'h5, 18'h00001);
        fire(parity_err_evt);
        check(fifth_mode_settings[4], 1'b1);
        check(parity_check_en, 1'b0);
        fire(crc_err_evt);
        step(20);
        check(fifth_mode_settings[4:3], 2'h3);
        mr(3'h5, 18'h00201);
        check(fifth_mode_settings[4:3], 2'h0);
        fire(parity_err_evt);
        check(fifth_mode_settings[4], 1'b1);
        check(parity_check_en, 1'b1);
        for (int k = 1; k < 6; k++) begin
            mr(3'h4, {9'h0, k[2:0], 6'h0});
            cal = cal_tab[k];
            check(cfg.cal_clocks, cal_tab[k]);
        end
        cal = 0;
        mr(3'h5, 18'h00c00);
        check(fifth_mode_settings[17:0], 18'h00211);
        cal = 8;
        mr(3'h4, 18'h01c3c);
        cal = 0;
        dq_ref_level = 1'b1;
        step(1);
        check(fourth_mode_settings[17:0], 18'h01c3c);
        check({cfg.rd_pre_clocks, cfg.ext_range}, 3'h5);
        check(refresh_ok, 1);
        check({dq_mon_out, dq_mon_oe}, 8'hff);
        chg = 0;
        s0 = pts;
        repeat (8) begin
            u_dmr_ctrl_model.pulse();
            chg += (pts !== s0);
            s0 = pts;
        end
        check(chg, 8);
        repair_bank = 4'h3;
        repair_row = 18'h01234;
        fire(repair_req);
        {lookup_bank, lookup_row} = {4'h3, 18'h01234};
        step(1);
        check(lookup_hit, 1'b1);
        repair_row = 18'h00abc;
        fire(repair_req);
        check(lookup_hit, 1'b0);
        lookup_row = 18'h00abc;
        step(1);
        check(lookup_hit, 1'b1);
        fire(power_down);
        check(lookup_hit, 1'b0);
        mr(3'h4, 18'h00002);
        mr(3'h5, 18'h00400);
        check(fifth_mode_settings[17:0], 18'h00211);
        fire(mpsm_exit);
        mr(3'h5, 18'h00400);
        check({fourth_mode_settings[1], fifth_mode_settings[17:0]},
              19'h00400);
        end_sim();
    end
endmodule
